//--- atlm_map.vh
`ifndef ATLM_MAP_VH
`define ATLM_MAP_VH

// Register byte addresses.
`define ATLM_CTRL_ADDR 8'h00
`define ATLM_TWIN_ADDR 8'h04
`define ATLM_UPPER_ADDR 8'h08
`define ATLM_LOWER_ADDR 8'h0C
`define ATLM_CMD_ADDR 8'h10
`define ATLM_ARG_ADDR 8'h14
`define ATLM_REPLY_ADDR 8'h18
`define ATLM_STATUS_ADDR 8'h1C
`define ATLM_ISTAT_ADDR 8'h20
`define ATLM_IMASK_ADDR 8'h24
`define ATLM_CPOS_ADDR 8'h28
`define ATLM_TREP_ADDR 8'h2C
`define ATLM_KP_ADDR 8'h30
`define ATLM_KV_ADDR 8'h34
`define ATLM_KS_ADDR 8'h38
`define ATLM_CAM_ADDR 8'h3C

// Control register bit positions and reset value.
`define ATLM_CTRL_ABORT_EN 0
`define ATLM_CTRL_SOFT_EN 1
`define ATLM_CTRL_SERVO 2
`define ATLM_CTRL_DUAL 3
`define ATLM_CTRL_VERBOSE 4
`define ATLM_CTRL_RST 5'h17

// Reset values and the tune amplitude.
`define ATLM_TWIN_RST 32'h0000_0FA0
`define ATLM_UPPER_RST 32'h0BEB_C200
`define ATLM_LOWER_RST 32'h8000_0001
`define ATLM_CAM_RST 8'hFF
`define ATLM_TUNE_AMP 32'h0000_0010

// Command codes, written to the command register.
`define ATLM_C_MOVE_ABS 4'h1
`define ATLM_C_MOVE_REL 4'h2
`define ATLM_C_CONST_VEL 4'h3
`define ATLM_C_STOP 4'h4
`define ATLM_C_RESET 4'h5
`define ATLM_C_TUNE 4'h6
`define ATLM_C_CAM_UNDEF 4'h7

// Reply codes.
`define ATLM_R_OK 4'h0
`define ATLM_R_RANGE 4'h1
`define ATLM_R_CONFLICT 4'h2
`define ATLM_R_TRACK 4'h3
`define ATLM_R_STALL 4'h4
`define ATLM_R_INPUT 4'h5
`define ATLM_R_TIMEOUT 4'h6
`define ATLM_R_HARD 4'h7
`define ATLM_R_SOFT 4'h8
`define ATLM_R_STEPPER 4'h9
`define ATLM_R_TUNE_FAIL 4'hA
`define ATLM_R_TUNE_REPORT 4'hB
`define ATLM_R_BUSY 4'hC
`define ATLM_R_NOT_ALLOWED 4'hD

// Timing.
`define ATLM_CLK_HZ 25000000
`define ATLM_STEP_NS 40000
`define ATLM_TUNE_MS 2000
`define ATLM_REV_MS 100

`endif

//--- atlm_core.v
// The address map and the AHB-Lite slave port are this design's own decisions.
`timescale 1ns/10ps
`include "atlm_map.vh"
module atlm_core #(
	parameter TUNE_CYCLES = `ATLM_TUNE_MS * (`ATLM_CLK_HZ / 1000),
	parameter TUNE_HALF = `ATLM_REV_MS * (`ATLM_CLK_HZ / 1000)
) (
	input wire hclk,
	input wire hresetn,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output wire hreadyout,
	output reg [31:0] hrdata,
	output wire hresp,
	input wire [31:0] actual_pos,
	input wire hard_limit_up,
	input wire hard_limit_dn,
	input wire jog_up,
	input wire jog_dn,
	input wire input_abort,
	input wire stall_abort,
	input wire timeout_abort,
	output reg [31:0] cmd_pos,
	output wire moving,
	output reg track_fault_disp,
	output reg error_out,
	output wire irq
);
	localparam ST_IDLE = 3'd0;
	localparam ST_MOVE = 3'd1;
	localparam ST_CV = 3'd2;
	localparam ST_JOG = 3'd3;
	localparam ST_TUNE = 3'd4;
	localparam [31:0] STEP_CYC = (`ATLM_STEP_NS * (`ATLM_CLK_HZ / 1000000)) / 1000;
	localparam [15:0] STEP_LAST = STEP_CYC[15:0] - 16'h0001;
	localparam [31:0] TUNE_LAST = TUNE_CYCLES - 1;
	localparam [31:0] HALF_LAST = TUNE_HALF - 1;

	reg [2:0] st;
	reg [4:0] ctrl;
	reg [31:0] track_win;
	reg [31:0] upper_lim;
	reg [31:0] lower_lim;
	reg [31:0] move_arg;
	reg [31:0] target;
	reg cv_up;
	reg [3:0] reply;
	reg track_abort;
	reg [7:0] cam_valid;
	reg [31:0] kp;
	reg [31:0] kv;
	reg [31:0] ks;
	reg [31:0] tune_rep;
	reg [31:0] tune_base;
	reg [31:0] tune_cnt;
	reg [31:0] half_cnt;
	reg tune_phase;
	reg [15:0] rev_cnt;
	reg [32:0] peak;
	reg [15:0] step_cnt;
	reg [3:0] pin_meta;
	reg [3:0] pin_sync;
	reg [3:0] irq_stat;
	reg [3:0] irq_mask;
	reg ev_reply;
	reg ev_abort;
	reg ev_done;
	reg wr_pend;
	reg [7:0] wr_addr;

	// The slave never stalls and always answers OKAY.
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign moving = (st != ST_IDLE);
	assign irq = |(irq_stat & irq_mask);

	wire abort_en = ctrl[`ATLM_CTRL_ABORT_EN];
	wire soft_en = ctrl[`ATLM_CTRL_SOFT_EN];
	wire servo = ctrl[`ATLM_CTRL_SERVO];
	wire hard_up = pin_sync[0];
	wire hard_dn = pin_sync[1];
	wire jog_up_s = pin_sync[2];
	wire jog_dn_s = pin_sync[3];
	wire addr_ok = hsel & htrans[1] & hready;
	wire tick = (step_cnt == STEP_LAST);

	// Signed difference, then its magnitude, so a lag or a lead both count.
	wire [32:0] pos_err = {cmd_pos[31], cmd_pos} - {actual_pos[31], actual_pos};
	wire [32:0] err_mag = pos_err[32] ? (33'h0_0000_0000 - pos_err) : pos_err;
	wire track_over = err_mag > {2'b00, track_win[30:0]};

	// Room left for one more step in each direction.
	wire up_ok = !(soft_en && ($signed(cmd_pos) >= $signed(upper_lim))) && !hard_up;
	wire dn_ok = !(soft_en && ($signed(cmd_pos) <= $signed(lower_lim))) && !hard_dn;

	// Abort sources in their reporting order.
	reg [3:0] abort_code;
	always @* begin
		if (track_abort) begin
			abort_code = `ATLM_R_TRACK;
		end else if (input_abort) begin
			abort_code = `ATLM_R_INPUT;
		end else if (stall_abort) begin
			abort_code = `ATLM_R_STALL;
		end else if (timeout_abort) begin
			abort_code = `ATLM_R_TIMEOUT;
		end else begin
			abort_code = `ATLM_R_OK;
		end
	end

	// Move destination for the command being written, checked against the window.
	wire [3:0] cmd_code = hwdata[3:0];
	wire [31:0] new_tgt = (cmd_code == `ATLM_C_MOVE_REL) ? (cmd_pos + move_arg) : move_arg;
	wire tgt_out = soft_en && (($signed(new_tgt) > $signed(upper_lim)) ||
		($signed(new_tgt) < $signed(lower_lim)));

	// Limit and jog pins come from outside; two flops before anything reads them.
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pin_meta <= 4'h0;
			pin_sync <= 4'h0;
		end else begin
			pin_meta <= {jog_dn, jog_up, hard_limit_dn, hard_limit_up};
			pin_sync <= pin_meta;
		end
	end

	// Address phase capture; read data is registered so it stands in the data phase.
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend <= 1'b0;
			wr_addr <= 8'h00;
			hrdata <= 32'h0000_0000;
		end else begin
			wr_pend <= addr_ok & hwrite & (hsize == 3'b010) & (haddr[31:8] == 24'h00_0000);
			wr_addr <= haddr[7:0];
			if (addr_ok && !hwrite) begin
				if (haddr[31:8] != 24'h00_0000) begin
					hrdata <= 32'h0000_0000;
				end else if (haddr[7:0] == `ATLM_CTRL_ADDR) begin
					hrdata <= {27'h000_0000, ctrl};
				end else if (haddr[7:0] == `ATLM_TWIN_ADDR) begin
					hrdata <= track_win;
				end else if (haddr[7:0] == `ATLM_UPPER_ADDR) begin
					hrdata <= upper_lim;
				end else if (haddr[7:0] == `ATLM_LOWER_ADDR) begin
					hrdata <= lower_lim;
				end else if (haddr[7:0] == `ATLM_ARG_ADDR) begin
					hrdata <= move_arg;
				end else if (haddr[7:0] == `ATLM_REPLY_ADDR) begin
					hrdata <= {28'h000_0000, reply};
				end else if (haddr[7:0] == `ATLM_STATUS_ADDR) begin
					hrdata <= {20'h0_0000, hard_dn, hard_up, timeout_abort, stall_abort,
						input_abort, track_abort, track_fault_disp, 2'b00, st};
				end else if (haddr[7:0] == `ATLM_ISTAT_ADDR) begin
					hrdata <= {28'h000_0000, irq_stat};
				end else if (haddr[7:0] == `ATLM_IMASK_ADDR) begin
					hrdata <= {28'h000_0000, irq_mask};
				end else if (haddr[7:0] == `ATLM_CPOS_ADDR) begin
					hrdata <= cmd_pos;
				end else if (haddr[7:0] == `ATLM_TREP_ADDR) begin
					hrdata <= tune_rep;
				end else if (haddr[7:0] == `ATLM_KP_ADDR) begin
					hrdata <= kp;
				end else if (haddr[7:0] == `ATLM_KV_ADDR) begin
					hrdata <= kv;
				end else if (haddr[7:0] == `ATLM_KS_ADDR) begin
					hrdata <= ks;
				end else if (haddr[7:0] == `ATLM_CAM_ADDR) begin
					hrdata <= {24'h00_0000, cam_valid};
				end else begin
					hrdata <= 32'h0000_0000;
				end
			end
		end
	end

	// Sticky interrupt bits; an event in the clearing cycle survives the clear.
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_stat <= 4'h0;
			irq_mask <= 4'h0;
		end else begin
			if (wr_pend && (wr_addr == `ATLM_IMASK_ADDR)) begin
				irq_mask <= hwdata[3:0];
			end
			irq_stat <= (irq_stat & ~((wr_pend && (wr_addr == `ATLM_ISTAT_ADDR)) ?
				hwdata[3:0] : 4'h0)) | {ev_done, ev_abort, track_over & ~track_fault_disp,
				ev_reply};
		end
	end

	// Motion, tuning, configuration writes and commands share one process so each
	// state bit has a single owner; later assignments take priority.
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st <= ST_IDLE;
			ctrl <= `ATLM_CTRL_RST;
			track_win <= `ATLM_TWIN_RST;
			upper_lim <= `ATLM_UPPER_RST;
			lower_lim <= `ATLM_LOWER_RST;
			move_arg <= 32'h0000_0000;
			target <= 32'h0000_0000;
			cv_up <= 1'b0;
			reply <= `ATLM_R_OK;
			track_abort <= 1'b0;
			cam_valid <= `ATLM_CAM_RST;
			kp <= 32'h0000_0000;
			kv <= 32'h0000_0000;
			ks <= 32'h0000_0000;
			tune_rep <= 32'h0000_0000;
			tune_base <= 32'h0000_0000;
			tune_cnt <= 32'h0000_0000;
			half_cnt <= 32'h0000_0000;
			tune_phase <= 1'b0;
			rev_cnt <= 16'h0000;
			peak <= 33'h0_0000_0000;
			step_cnt <= 16'h0000;
			cmd_pos <= 32'h0000_0000;
			track_fault_disp <= 1'b0;
			error_out <= 1'b0;
			ev_reply <= 1'b0;
			ev_abort <= 1'b0;
			ev_done <= 1'b0;
		end else begin
			ev_reply <= 1'b0;
			ev_abort <= 1'b0;
			ev_done <= 1'b0;
			step_cnt <= tick ? 16'h0000 : (step_cnt + 16'h0001);
			track_fault_disp <= track_over;
			error_out <= track_abort;
			case (st)
			ST_MOVE: begin
				if (cmd_pos == target) begin
					st <= ST_IDLE;
					ev_done <= 1'b1;
				end else if (tick) begin
					// A hard limit ends the move even with soft limits off.
					if ($signed(target) > $signed(cmd_pos)) begin
						if (hard_up) begin
							st <= ST_IDLE;
						end else begin
							cmd_pos <= cmd_pos + 32'h0000_0001;
						end
					end else if (hard_dn) begin
						st <= ST_IDLE;
					end else begin
						cmd_pos <= cmd_pos - 32'h0000_0001;
					end
				end
			end
			ST_CV: begin
				if (tick) begin
					if (cv_up ? !up_ok : !dn_ok) begin
						st <= ST_IDLE;
						ev_done <= 1'b1;
					end else if (cv_up) begin
						cmd_pos <= cmd_pos + 32'h0000_0001;
					end else begin
						cmd_pos <= cmd_pos - 32'h0000_0001;
					end
				end
			end
			ST_JOG: begin
				if (!jog_up_s && !jog_dn_s) begin
					st <= ST_IDLE;
				end else if (tick && jog_up_s && up_ok) begin
					cmd_pos <= cmd_pos + 32'h0000_0001;
				end else if (tick && jog_dn_s && !jog_up_s && dn_ok) begin
					cmd_pos <= cmd_pos - 32'h0000_0001;
				end
			end
			ST_TUNE: begin
				// Swing about the start point and record the largest following error.
				if (err_mag > peak) begin
					peak <= err_mag;
				end
				tune_cnt <= tune_cnt + 32'h0000_0001;
				if (half_cnt == HALF_LAST) begin
					half_cnt <= 32'h0000_0000;
					tune_phase <= ~tune_phase;
					rev_cnt <= rev_cnt + 16'h0001;
					cmd_pos <= tune_phase ? (tune_base - `ATLM_TUNE_AMP) :
						(tune_base + `ATLM_TUNE_AMP);
				end else begin
					half_cnt <= half_cnt + 32'h0000_0001;
				end
				if (tune_cnt == TUNE_LAST) begin
					st <= ST_IDLE;
					ev_done <= 1'b1;
					ev_reply <= 1'b1;
					cmd_pos <= tune_base;
					if ((peak[32:16] != 17'h0_0000) || (peak == 33'h0_0000_0000)) begin
						reply <= `ATLM_R_TUNE_FAIL;
					end else begin
						// The loop gains and the tune report change; a stiffer axis earns more kp but less kv and ks.
						kp <= 32'h0001_0000 - {16'h0000, peak[15:0]};
						kv <= {16'h0000, peak[15:0]};
						ks <= {17'h0_0000, peak[15:1]};
						tune_rep <= {rev_cnt, peak[15:0]};
						reply <= ctrl[`ATLM_CTRL_VERBOSE] ? `ATLM_R_TUNE_REPORT :
							`ATLM_R_OK;
					end
				end
			end
			default: begin
				if ((jog_up_s || jog_dn_s) && (abort_code == `ATLM_R_OK)) begin
					st <= ST_JOG;
				end
			end
			endcase

			if (wr_pend) begin
				if (wr_addr == `ATLM_CTRL_ADDR) begin
					ctrl <= hwdata[4:0];
				end else if (wr_addr == `ATLM_TWIN_ADDR) begin
					ev_reply <= 1'b1;
					if (hwdata[31]) begin
						reply <= `ATLM_R_RANGE;
					end else begin
						track_win <= hwdata;
						reply <= `ATLM_R_OK;
					end
				end else if (wr_addr == `ATLM_UPPER_ADDR) begin
					ev_reply <= 1'b1;
					if ($signed(hwdata) <= $signed(lower_lim)) begin
						reply <= `ATLM_R_CONFLICT;
					end else begin
						upper_lim <= hwdata;
						reply <= `ATLM_R_OK;
					end
				end else if (wr_addr == `ATLM_LOWER_ADDR) begin
					ev_reply <= 1'b1;
					if ($signed(hwdata) >= $signed(upper_lim)) begin
						reply <= `ATLM_R_CONFLICT;
					end else begin
						lower_lim <= hwdata;
						reply <= `ATLM_R_OK;
					end
				end else if (wr_addr == `ATLM_ARG_ADDR) begin
					move_arg <= hwdata;
				end else if (wr_addr == `ATLM_CAM_ADDR) begin
					cam_valid <= cam_valid | hwdata[7:0];
				end else if (wr_addr == `ATLM_CMD_ADDR) begin
					ev_reply <= 1'b1;
					reply <= `ATLM_R_OK;
					if (cmd_code == `ATLM_C_RESET) begin
						track_abort <= 1'b0;
						st <= ST_IDLE;
					end else if (cmd_code == `ATLM_C_STOP) begin
						if (st == ST_IDLE) begin
							reply <= `ATLM_R_NOT_ALLOWED;
						end else begin
							st <= ST_IDLE;
							cmd_pos <= (st == ST_TUNE) ? tune_base : cmd_pos;
						end
					end else if ((cmd_code == `ATLM_C_MOVE_ABS) ||
						(cmd_code == `ATLM_C_MOVE_REL) || (cmd_code == `ATLM_C_CONST_VEL)) begin
						if (abort_code != `ATLM_R_OK) begin
							reply <= abort_code;
						end else if (st != ST_IDLE) begin
							reply <= `ATLM_R_BUSY;
						end else if (cmd_code == `ATLM_C_CONST_VEL) begin
							cv_up <= ~move_arg[31];
							if (move_arg[31] ? !dn_ok : !up_ok) begin
								reply <= `ATLM_R_SOFT;
							end else begin
								st <= ST_CV;
							end
						end else if (tgt_out) begin
							reply <= `ATLM_R_SOFT;
						end else begin
							target <= new_tgt;
							st <= ST_MOVE;
						end
					end else if (cmd_code == `ATLM_C_TUNE) begin
						if (!servo) begin
							reply <= `ATLM_R_STEPPER;
						end else if (st != ST_IDLE) begin
							reply <= `ATLM_R_BUSY;
						end else if (abort_code != `ATLM_R_OK) begin
							reply <= abort_code;
						end else if (hard_up) begin
							reply <= `ATLM_R_HARD;
						end else if (soft_en && ($signed(cmd_pos) >= $signed(upper_lim))) begin
							reply <= `ATLM_R_SOFT;
						end else if (ctrl[`ATLM_CTRL_DUAL]) begin
							reply <= `ATLM_R_TUNE_FAIL;
						end else begin
							// The tune reply is posted when the exercise ends.
							ev_reply <= 1'b0;
							st <= ST_TUNE;
							tune_base <= cmd_pos;
							tune_cnt <= 32'h0000_0000;
							half_cnt <= 32'h0000_0000;
							tune_phase <= 1'b0;
							rev_cnt <= 16'h0000;
							peak <= 33'h0_0000_0000;
						end
					end else if (cmd_code == `ATLM_C_CAM_UNDEF) begin
						if (!servo) begin
							reply <= `ATLM_R_STEPPER;
						end else if (st != ST_IDLE) begin
							reply <= `ATLM_R_BUSY;
						end else begin
							cam_valid[hwdata[6:4]] <= 1'b0;
						end
					end else begin
						reply <= `ATLM_R_NOT_ALLOWED;
					end
				end
			end

			// Abort beats any move started in the same cycle.
			if (track_over && abort_en && !track_abort) begin
				track_abort <= 1'b1;
				ev_abort <= 1'b1;
				st <= ST_IDLE;
			end
		end
	end
endmodule

//--- atlm_motor.sv
`timescale 1ns/10ps
// Simple axis model: the encoder follows the commanded position one cycle late.
// The lag gives the tuning logic a real following error to measure, and the
// offset lets the bench push the axis outside the tracking window on purpose.
module atlm_motor (
	input wire hclk,
	input wire hresetn,
	input wire [31:0] cmd_pos,
	input wire [31:0] offset,
	output reg [31:0] actual_pos
);
	// Registered follower with a bench-controlled error.
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			actual_pos <= 32'h0000_0000;
		end else begin
			actual_pos <= cmd_pos + offset;
		end
	end
endmodule

//--- atlm_core_props.sv
`timescale 1ns/10ps
`include "atlm_map.vh"
module atlm_core_props (
	input wire hclk,
	input wire hresetn,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire hready,
	input wire [31:0] hwdata,
	input wire hreadyout,
	input wire hresp,
	input wire [31:0] hrdata,
	input wire [31:0] cmd_pos,
	input wire moving,
	input wire track_fault_disp,
	input wire error_out
);
	reg rd_req;
	reg cmd_wr;
	reg tune_run;
	// Remember a read address phase; read data may change only after one.
	// A tune swings the command position by whole amplitudes, so unit steps are
	// only required outside a tune; tune_run lasts from the command until motion ends.
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rd_req <= 1'b0;
			cmd_wr <= 1'b0;
			tune_run <= 1'b0;
		end else begin
			rd_req <= hsel & htrans[1] & ~hwrite & hreadyout;
			cmd_wr <= hsel & htrans[1] & hwrite & hready &
				(haddr == {24'h00_0000, `ATLM_CMD_ADDR});
			if (cmd_wr && (hwdata[3:0] == `ATLM_C_TUNE)) begin
				tune_run <= 1'b1;
			end else if (!moving) begin
				tune_run <= 1'b0;
			end
		end
	end
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	sequence s_err_up;
		$rose(error_out);
	endsequence
	sequence s_step;
		moving && $past(moving) && !tune_run && $changed(cmd_pos);
	endsequence
	property p_bus_ok;
		hreadyout && !hresp;
	endproperty
	property p_rd_hold;
		!rd_req |-> $stable(hrdata);
	endproperty
	property p_err_cause;
		s_err_up |-> $past(track_fault_disp);
	endproperty
	property p_err_stop;
		s_err_up |-> !$past(moving);
	endproperty
	property p_err_idle;
		error_out |-> !moving;
	endproperty
	property p_err_sticky;
		s_err_up |=> error_out [*2];
	endproperty
	property p_err_clear;
		$fell(error_out) |-> $past(hwrite, 2) || $past(hwrite, 3) || $past(hwrite, 4);
	endproperty
	property p_step_unit;
		s_step |-> (cmd_pos - $past(cmd_pos) == 32'h0000_0001) ||
			($past(cmd_pos) - cmd_pos == 32'h0000_0001);
	endproperty
	a_bus_ok: assert property (p_bus_ok) else $error("bus not ready or not okay");
	a_rd_hold: assert property (p_rd_hold) else $error("read data changed without a read");
	a_err_cause: assert property (p_err_cause) else $error("error output without fault");
	a_err_stop: assert property (p_err_stop) else $error("abort left the axis moving");
	a_err_idle: assert property (p_err_idle) else $error("motion while aborted");
	a_err_sticky: assert property (p_err_sticky) else $error("abort did not latch");
	a_err_clear: assert property (p_err_clear) else $error("abort cleared without write");
	a_step_unit: assert property (p_step_unit) else $error("command position jumped");
endmodule
bind atlm_core atlm_core_props atlm_core_props_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
	.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hwdata(hwdata),
	.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
	.cmd_pos(cmd_pos), .moving(moving), .track_fault_disp(track_fault_disp),
	.error_out(error_out));

//--- axis_tracking_limit_monitor_test.sv
`timescale 1ns/10ps
`include "atlm_map.vh"
module axis_tracking_limit_monitor_test;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0000_0000;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0000_0000;
	logic [6:0] pins = 7'h00;
	logic [31:0] offset = 32'h0000_0000;
	logic [31:0] rdata;
	integer errors = 0;
	integer check_count = 0;
	wire hreadyout, hresp, moving, track_fault_disp, error_out, irq;
	wire [31:0] hrdata, cmd_pos, actual_pos;
	// Short tuning counts keep the run brief; all waits below are bounded anyway.
	atlm_core #(.TUNE_CYCLES(2000), .TUNE_HALF(100)) atlm_core_i (.hclk(hclk),
		.hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hrdata(hrdata), .hresp(hresp), .actual_pos(actual_pos), .hard_limit_up(pins[0]),
		.hard_limit_dn(pins[1]), .jog_up(pins[5]), .jog_dn(pins[6]), .input_abort(pins[2]),
		.stall_abort(pins[3]), .timeout_abort(pins[4]), .cmd_pos(cmd_pos), .moving(moving),
		.track_fault_disp(track_fault_disp), .error_out(error_out), .irq(irq));
	atlm_motor atlm_motor_i (.hclk(hclk), .hresetn(hresetn), .cmd_pos(cmd_pos),
		.offset(offset), .actual_pos(actual_pos));
	// Free-running bus clock.
	always #20 hclk = ~hclk;
	task conclude;
		$display("checks %0d mismatches %0d", check_count, errors);
		if (errors == 0 && check_count > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task chk(input [31:0] got, input [31:0] exp);
		check_count = check_count + 1;
		if (got !== exp) begin
			errors = errors + 1;
			$display("FAIL %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task tick(input integer n);
		repeat (n) @(posedge hclk);
	endtask
	// Wait for the slave to accept the current phase, never forever.
	task bus_wait;
		integer n;
		n = 0;
		@(posedge hclk);
		while (hreadyout !== 1'b1) begin
			n = n + 1;
			if (n > 100) begin
				errors = errors + 1;
				conclude;
			end
			@(posedge hclk);
		end
	endtask
	task wr(input [31:0] a, input [31:0] d);
		hsel <= 1'b1; haddr <= a; htrans <= 2'h2; hwrite <= 1'b1;
		bus_wait;
		htrans <= 2'h0; hwrite <= 1'b0; hwdata <= d;
		bus_wait;
	endtask
	task rdc(input [31:0] a, input [31:0] exp);
		hsel <= 1'b1; haddr <= a; htrans <= 2'h2; hwrite <= 1'b0;
		bus_wait;
		htrans <= 2'h0;
		bus_wait;
		rdata = hrdata;
		chk(rdata, exp);
	endtask
	task cmd(input [31:0] c, input [31:0] a);
		wr(`ATLM_ARG_ADDR, a);
		wr(`ATLM_CMD_ADDR, c);
	endtask
	task reply(input [3:0] r);
		rdc(`ATLM_REPLY_ADDR, {28'h000_0000, r});
	endtask
	// A move or tune must end within a bounded time.
	task wait_idle;
		integer n;
		n = 0;
		while (moving !== 1'b0 && n < 20000) begin
			tick(1);
			n = n + 1;
		end
		if (n >= 20000) begin
			errors = errors + 1;
			conclude;
		end
	endtask
	initial begin
		tick(6);
		hresetn <= 1'b1;
		rdc(`ATLM_CTRL_ADDR, 32'h0000_0017);
		rdc(`ATLM_TWIN_ADDR, 32'h0000_0FA0);
		rdc(`ATLM_UPPER_ADDR, 32'h0BEB_C200);
		wr(`ATLM_TWIN_ADDR, 32'h8000_0000);
		reply(`ATLM_R_RANGE);
		rdc(`ATLM_TWIN_ADDR, 32'h0000_0FA0);
		wr(`ATLM_TWIN_ADDR, 32'h7FFF_FFFF);
		rdc(`ATLM_TWIN_ADDR, 32'h7FFF_FFFF);
		wr(`ATLM_TWIN_ADDR, 32'h0000_000A);
		wr(`ATLM_UPPER_ADDR, 32'h8000_0001);
		reply(`ATLM_R_CONFLICT);
		wr(`ATLM_UPPER_ADDR, 32'h0000_0002);
		reply(`ATLM_R_OK);
		cmd(`ATLM_C_MOVE_ABS, 32'h0000_0003);
		reply(`ATLM_R_SOFT);
		cmd(`ATLM_C_MOVE_REL, 32'h0000_0003);
		reply(`ATLM_R_SOFT);
		wr(`ATLM_CTRL_ADDR, 32'h0000_0015);
		cmd(`ATLM_C_MOVE_ABS, 32'h0000_0003);
		tick(1);
		chk(moving, 1'b1);
		wait_idle;
		chk(cmd_pos, 32'h0000_0003);
		chk(track_fault_disp, 1'b0);
		// Fault with abort inhibited, deviation of either sign.
		wr(`ATLM_CTRL_ADDR, 32'h0000_0014);
		offset <= 32'h0000_000B;
		tick(4);
		chk(track_fault_disp, 1'b1);
		chk(error_out, 1'b0);
		offset <= 32'hFFFF_FFF5;
		tick(4);
		chk(track_fault_disp, 1'b1);
		offset <= 32'h0000_000A;
		tick(4);
		chk(track_fault_disp, 1'b0);
		wr(`ATLM_ISTAT_ADDR, 32'h0000_000F);
		wr(`ATLM_IMASK_ADDR, 32'h0000_0004);
		offset <= 32'h0000_000B;
		wr(`ATLM_CTRL_ADDR, 32'h0000_0015);
		tick(4);
		chk(error_out, 1'b1);
		chk(irq, 1'b1);
		rdc(`ATLM_STATUS_ADDR, 32'h0000_0060);
		cmd(`ATLM_C_MOVE_REL, 32'h0000_0001);
		reply(`ATLM_R_TRACK);
		chk(moving, 1'b0);
		cmd(`ATLM_C_TUNE, 32'h0000_0000);
		reply(`ATLM_R_TRACK);
		wr(`ATLM_IMASK_ADDR, 32'h0000_0000);
		tick(1);
		chk(irq, 1'b0);
		wr(`ATLM_IMASK_ADDR, 32'h0000_0004);
		wr(`ATLM_ISTAT_ADDR, 32'h0000_0004);
		tick(1);
		chk(irq, 1'b0);
		offset <= 32'h0000_0000;
		cmd(`ATLM_C_RESET, 32'h0000_0000);
		tick(2);
		chk(error_out, 1'b0);
		// Mode and fault gating of tune, and mode gating of cam undefine.
		wr(`ATLM_CTRL_ADDR, 32'h0000_0000);
		cmd(`ATLM_C_TUNE, 32'h0000_0000);
		reply(`ATLM_R_STEPPER);
		cmd(32'h0000_0037, 32'h0000_0000);
		reply(`ATLM_R_STEPPER);
		rdc(`ATLM_CAM_ADDR, 32'h0000_00FF);
		wr(`ATLM_CTRL_ADDR, 32'h0000_001C);
		cmd(`ATLM_C_TUNE, 32'h0000_0000);
		reply(`ATLM_R_TUNE_FAIL);
		wr(`ATLM_CTRL_ADDR, 32'h0000_0016);
		cmd(`ATLM_C_TUNE, 32'h0000_0000);
		reply(`ATLM_R_SOFT);
		cmd(`ATLM_C_CONST_VEL, 32'h0000_0001);
		reply(`ATLM_R_SOFT);
		// A downward run is inside the limits; stop ends it, and a second stop is refused.
		cmd(`ATLM_C_CONST_VEL, 32'hFFFF_FFFF);
		tick(1);
		chk(moving, 1'b1);
		cmd(`ATLM_C_STOP, 32'h0000_0000);
		reply(`ATLM_R_OK);
		chk(moving, 1'b0);
		cmd(`ATLM_C_STOP, 32'h0000_0000);
		reply(`ATLM_R_NOT_ALLOWED);
		wr(`ATLM_CTRL_ADDR, 32'h0000_0014);
		pins <= 7'h01;
		tick(3);
		cmd(`ATLM_C_TUNE, 32'h0000_0000);
		reply(`ATLM_R_HARD);
		pins <= 7'h04;
		tick(3);
		cmd(`ATLM_C_TUNE, 32'h0000_0000);
		reply(`ATLM_R_INPUT);
		pins <= 7'h00;
		cmd(32'h0000_0037, 32'h0000_0000);
		reply(`ATLM_R_OK);
		rdc(`ATLM_CAM_ADDR, 32'h0000_00F7);
		cmd(`ATLM_C_TUNE, 32'h0000_0000);
		tick(1);
		chk(moving, 1'b1);
		wait_idle;
		reply(`ATLM_R_TUNE_REPORT);
		wr(`ATLM_CTRL_ADDR, 32'h0000_0004);
		cmd(`ATLM_C_TUNE, 32'h0000_0000);
		tick(1);
		wait_idle;
		reply(`ATLM_R_OK);
		conclude;
	end
endmodule
